// ===== fl_entry_if.sv
/*
  Carrier between the register bank and one table entry evaluator.
  Assumes the bank drives settings and the evaluator answers
  combinationally.
*/
`default_nettype none

interface fl_entry_if;
  logic [7:0] thr;
  logic [7:0] duty;
  logic       temp_hr;
  logic       duty_hr;
  logic       freq_22k;
  logic [7:0] tofs;
  logic [8:0] temp;
  logic       hit;
  logic [7:0] pwm;

  modport entry (
    input  thr, duty, temp_hr, duty_hr, freq_22k, tofs, temp,
    output hit, pwm
  );
  modport bank (
    output thr, duty, temp_hr, duty_hr, freq_22k, tofs, temp,
    input  hit, pwm
  );
endinterface : fl_entry_if

`default_nettype wire

// ===== fl_lut_entry.sv
/*
  One lookup table entry: effective threshold, comparison against the
  remote temperature and the duty value it selects.
  Assumes temperature in half degree units, unsigned, 0..255.5 C.
*/
`default_nettype none

module fl_lut_entry
  import fl_pkg::*;
(
  fl_entry_if.entry e
);

  logic       thr_half;
  logic [9:0] thr_eff;
  logic [9:0] temp_cmp;
  logic [1:0] ext;

  always_comb begin
    // Half degree bit only counts in fine mode
    thr_half = e.temp_hr ? e.thr[TEMP_HALF_BIT] : 1'b0;
    // 0..127.5 C or 0..127 C, offset in whole degrees
    thr_eff  = {2'b00, e.thr[6:0], thr_half}
             + {1'b0, e.tofs, 1'b0};
    // Nine bits compared in fine mode, eight in coarse; sign taken as 0
    temp_cmp = {1'b0, e.temp[8:1],
                e.temp_hr ? e.temp[0] : 1'b0};
    e.hit    = temp_cmp > thr_eff;
    ext      = (e.duty_hr && e.freq_22k) ? e.duty[7:6]
                                         : 2'b00;
    e.pwm    = {ext, e.duty[5:0]};
  end

endmodule // fl_lut_entry

`default_nettype wire

// ===== fl_lut_nine_ten.sv
/*
  Register bank for fan lookup table entries nine and ten, with the
  configuration, table offset and status words, and the PWM duty pick.
  Assumes an APB master on pclk and a remote temperature sample that is
  synchronous to pclk, in half degree units.
*/
// The APB slave port is this design's own decision.
`default_nettype none

module fl_lut_nine_ten
  import fl_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [8:0]        remote_temp,
  output logic      [7:0]        pwm_duty,
  output logic                   lut_active
);

  logic [7:0]  cfg_q,    cfg_d;
  logic [7:0]  tofs_q,   tofs_d;
  logic [7:0]  thr9_q,   thr9_d;
  logic [7:0]  duty9_q,  duty9_d;
  logic [7:0]  thr10_q,  thr10_d;
  logic [7:0]  duty10_q, duty10_d;
  logic [31:0] prdata_q, prdata_d;
  logic [7:0]  pwm_q,    pwm_d;
  logic        act_q,    act_d;
  logic [7:0]  idx;
  logic        aligned;
  logic        mapped;
  logic        wr_en;
  logic        tab_wen;
  logic        temp_hr;
  logic        duty_hr;
  logic [7:0]  thr_wval;
  logic [7:0]  duty_wval;
  logic [7:0]  rd_word;

  fl_entry_if e9_if ();
  fl_entry_if e10_if ();

  // Address decode
  always_comb begin
    idx     = paddr[9:2];
    aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == 2'b00);
    mapped  = aligned && (idx == IDX_CFG  || idx == IDX_TOFS ||
                          idx == IDX_STAT || idx == IDX_T9   ||
                          idx == IDX_D9   || idx == IDX_T10  ||
                          idx == IDX_D10);
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_q;

  always_comb begin
    tab_wen = cfg_q[CFG_WEN_BIT];
    temp_hr = cfg_q[CFG_TEMP_HR_BIT];
    duty_hr = cfg_q[CFG_DUTY_HR_BIT];
    wr_en   = psel && penable && pwrite && mapped && pstrb[0];
    // Coarse modes store the unused bits as zero
    thr_wval  = temp_hr ? pwdata[7:0]
                        : {1'b0, pwdata[6:0]};
    duty_wval = duty_hr ? pwdata[7:0]
                        : {2'b00, pwdata[5:0]};
  end

  // Register writes
  always_comb begin
    cfg_d    = cfg_q;
    tofs_d   = tofs_q;
    thr9_d   = thr9_q;
    duty9_d  = duty9_q;
    thr10_d  = thr10_q;
    duty10_d = duty10_q;
    if (wr_en) begin
      if (idx == IDX_CFG) begin
        cfg_d = pwdata[7:0];
      end
      if (idx == IDX_TOFS) begin
        tofs_d = pwdata[7:0];
      end
      // Table words ignore writes while write enable is clear
      if (tab_wen) begin
        if (idx == IDX_T9) begin
          thr9_d = thr_wval;
        end
        if (idx == IDX_D9) begin
          duty9_d = duty_wval;
        end
        if (idx == IDX_T10) begin
          thr10_d = thr_wval;
        end
        if (idx == IDX_D10) begin
          duty10_d = duty_wval;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q    <= CFG_RST;
      tofs_q   <= TOFS_RST;
      thr9_q   <= THR_RST;
      duty9_q  <= DUTY_RST;
      thr10_q  <= THR_RST;
      duty10_q <= DUTY_RST;
    end else begin
      cfg_q    <= cfg_d;
      tofs_q   <= tofs_d;
      thr9_q   <= thr9_d;
      duty9_q  <= duty9_d;
      thr10_q  <= thr10_d;
      duty10_q <= duty10_d;
    end
  end

  // Read data, captured in the setup cycle
  always_comb begin
    rd_word  = 8'h00;
    prdata_d = prdata_q;
    unique case (idx)
      IDX_CFG:  rd_word = cfg_q;
      IDX_TOFS: rd_word = tofs_q;
      // Unused bits read as zero in coarse modes
      IDX_T9:   rd_word = temp_hr ? thr9_q
                                  : {1'b0, thr9_q[6:0]};
      IDX_T10:  rd_word = temp_hr ? thr10_q
                                  : {1'b0, thr10_q[6:0]};
      IDX_D9:   rd_word = duty_hr ? duty9_q
                                  : {2'b00, duty9_q[5:0]};
      IDX_D10:  rd_word = duty_hr ? duty10_q
                                  : {2'b00, duty10_q[5:0]};
      default:  rd_word = 8'h00;
    endcase
    if (psel && !penable && !pwrite) begin
      if (!mapped) begin
        prdata_d = 32'h0000_0000;
      end else if (idx == IDX_STAT) begin
        prdata_d = {21'h00_0000, act_q, e10_if.hit, e9_if.hit, pwm_q};
      end else begin
        prdata_d = {24'h00_0000, rd_word};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // Entry evaluators
  always_comb begin
    e9_if.thr       = thr9_q;
    e9_if.duty      = duty9_q;
    e9_if.temp_hr   = temp_hr;
    e9_if.duty_hr   = duty_hr;
    e9_if.freq_22k  = cfg_q[CFG_FREQ_22K_BIT];
    e9_if.tofs      = tofs_q;
    e9_if.temp      = remote_temp;
    e10_if.thr      = thr10_q;
    e10_if.duty     = duty10_q;
    e10_if.temp_hr  = temp_hr;
    e10_if.duty_hr  = duty_hr;
    e10_if.freq_22k = cfg_q[CFG_FREQ_22K_BIT];
    e10_if.tofs     = tofs_q;
    e10_if.temp     = remote_temp;
  end

  fl_lut_entry u_entry9 (
    .e (e9_if.entry)
  );

  fl_lut_entry u_entry10 (
    .e (e10_if.entry)
  );

  // Higher entry wins; no hit leaves the output at zero
  always_comb begin
    pwm_d = PWM_RST;
    act_d = 1'b0;
    if (e10_if.hit) begin
      pwm_d = e10_if.pwm;
      act_d = 1'b1;
    end else if (e9_if.hit) begin
      pwm_d = e9_if.pwm;
      act_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_q <= PWM_RST;
      act_q <= 1'b0;
    end else begin
      pwm_q <= pwm_d;
      act_q <= act_d;
    end
  end

  assign pwm_duty   = pwm_q;
  assign lut_active = act_q;

  // Independent model of entries nine and ten for checking
  logic [9:0] chk_thr9;
  logic [9:0] chk_thr10;
  logic [9:0] chk_temp;
  logic       chk_hit9;
  logic       chk_hit10;
  logic [7:0] chk_duty9;
  logic [7:0] chk_duty10;

  always_comb begin
    chk_thr9  = temp_hr ? {2'b00, thr9_q[6:0], thr9_q[7]}
                        : {2'b00, thr9_q[6:0], 1'b0};
    chk_thr9  = chk_thr9 + {1'b0, tofs_q, 1'b0};
    chk_thr10 = temp_hr ? {2'b00, thr10_q[6:0], thr10_q[7]}
                        : {2'b00, thr10_q[6:0], 1'b0};
    chk_thr10 = chk_thr10 + {1'b0, tofs_q, 1'b0};
    chk_temp  = temp_hr ? {1'b0, remote_temp}
                        : {1'b0, remote_temp[8:1], 1'b0};
    chk_hit9  = chk_temp > chk_thr9;
    chk_hit10 = chk_temp > chk_thr10;
    chk_duty9 = (duty_hr && cfg_q[CFG_FREQ_22K_BIT]) ? duty9_q
                : {2'b00, duty9_q[5:0]};
    chk_duty10 = (duty_hr && cfg_q[CFG_FREQ_22K_BIT]) ? duty10_q
                 : {2'b00, duty10_q[5:0]};
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup(logic [7:0] ix, logic wr);
    psel && !penable && (pwrite == wr) && aligned && (idx == ix);
  endsequence

  sequence s_access;
    psel && penable;
  endsequence

  // Accepted table write: table open, byte lane zero enabled
  sequence s_table_write(logic [7:0] ix);
    s_setup(ix, 1'b1) ##1 (s_access and (tab_wen && pstrb[0]));
  endsequence

  // Table write gating
  a_locked_thr_write: assert property (
    (s_setup(IDX_T9, 1'b1) ##1 (s_access and !tab_wen)) |=> $stable(thr9_q))
    else $error("threshold nine changed while table locked");

  a_locked_t10_write: assert property (
    (s_setup(IDX_T10, 1'b1) ##1 (s_access and !tab_wen))
    |=> $stable(thr10_q))
    else $error("threshold ten changed while table locked");

  a_open_thr_write: assert property (
    (s_table_write(IDX_T9) ##0 temp_hr)
    |=> thr9_q == $past(pwdata[7:0]))
    else $error("threshold nine write lost");

  // Field widths per mode as stored, read and driven; entry duty selection
  a_coarse_thr_store: assert property (
    (s_table_write(IDX_T9) ##0 !temp_hr)
    |=> thr9_q[TEMP_HALF_BIT] == 1'b0)
    else $error("half degree bit stored in coarse mode");

  a_coarse_duty_store: assert property (
    (s_table_write(IDX_D9) ##0 !duty_hr)
    |=> duty9_q[7:6] == 2'b00)
    else $error("duty extension stored in coarse mode");

  a_fine_duty_store: assert property (
    (s_table_write(IDX_D9) ##0 duty_hr)
    |=> duty9_q == $past(pwdata[7:0]))
    else $error("fine duty write lost");

  a_coarse_half_bit: assert property (
    (s_setup(IDX_T10, 1'b0) and !temp_hr) |=> prdata[7] == 1'b0)
    else $error("half degree bit visible in coarse mode");

  a_coarse_duty_ext: assert property (
    (s_setup(IDX_D9, 1'b0) and !duty_hr) |=> prdata[7:6] == 2'b00)
    else $error("duty extension visible in coarse mode");

  a_coarse_pwm_six: assert property (
    (!duty_hr ##1 !duty_hr) |-> pwm_duty[7:6] == 2'b00)
    else $error("coarse PWM uses upper duty bits");

  a_ext_needs_22k: assert property (
    (!cfg_q[CFG_FREQ_22K_BIT] ##1 !cfg_q[CFG_FREQ_22K_BIT])
    |-> pwm_duty[7:6] == 2'b00)
    else $error("duty extension used without 22.5 kHz");

  a_entry9_drive: assert property (
    (chk_hit9 && !e10_if.hit) |=> (lut_active
      && pwm_duty == $past(chk_duty9)))
    else $error("entry nine hit did not drive its duty");

  a_threshold_miss: assert property (
    (!chk_hit9 && !e10_if.hit) |=> (!lut_active && pwm_duty == 8'h00))
    else $error("PWM driven without a threshold crossed");

  a_entry10_drive: assert property (
    chk_hit10 |=> (lut_active && pwm_duty == $past(chk_duty10)))
    else $error("entry ten hit did not drive its duty");

  // Evaluators against the independent model
  a_hit9_model: assert property (
    e9_if.hit == chk_hit9)
    else $error("entry nine compare wrong");

  a_hit10_model: assert property (
    e10_if.hit == chk_hit10)
    else $error("entry ten compare wrong");

  a_unmapped_read: assert property (
    (psel && !penable && !pwrite && !mapped) |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  a_bus_answer: assert property (
    s_access |-> (pready && (pslverr == !mapped)))
    else $error("APB answer wrong");

endmodule // fl_lut_nine_ten

`default_nettype wire

// ===== fl_lut_nine_ten_tb.sv
/*
  Self-checking bench for the table entries nine and ten bank.
  Assumes the zero-wait APB slave and one-cycle PWM latency of the bank.
*/
`default_nettype none

module testbench
  import fl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [3:0]        pstrb;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [8:0]        remote_temp;
  logic [7:0]        pwm_duty;
  logic              lut_active;
  logic [31:0]       r;
  logic              e;
  int                mismatches;
  int                n_compared;

  fl_lut_nine_ten dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .remote_temp(remote_temp), .pwm_duty(pwm_duty),
    .lut_active(lut_active)
  );

  always #5 pclk = ~pclk;

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask

  // One transfer, entered and left just after a rising edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] x,
                    input string n);
    apb(1'b0, {2'b00, idx, 2'b00}, 32'h0);
    chk(n, {24'h0, x}, r);
    chk("pslverr", 32'h0, {31'h0, e});
  endtask

  task automatic tmp(input logic [8:0] t, input logic [7:0] p,
                     input logic act);
    remote_temp <= t;
    repeat (2) @(posedge pclk);
    chk("pwm_duty", {24'h0, p}, {24'h0, pwm_duty});
    chk("lut_active", {31'h0, act}, {31'h0, lut_active});
  endtask

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = '0; pwdata = '0; pstrb = 4'hF;
    remote_temp = 9'h000; mismatches = 0; n_compared = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(IDX_T9, 8'h7F, "t9");
    rd(IDX_D9, 8'h3F, "d9");
    rd(IDX_T10, 8'h7F, "t10");
    rd(IDX_D10, 8'h3F, "d10");
    apb(1'b0, 12'hC00, 32'h0);
    chk("unmapped data", 32'h0, r);
    chk("unmapped err", 32'h1, {31'h0, e});
    tmp(9'h1FF, 8'h3F, 1'b1);
    tmp(9'd255, 8'h00, 1'b0);
    wr(IDX_T9, 8'h32);
    rd(IDX_T9, 8'h7F, "t9 locked");
    wr(IDX_CFG, 8'h20);
    wr(IDX_T9, 8'hB2);
    rd(IDX_T9, 8'h32, "t9 coarse");
    pstrb <= 4'h0;
    wr(IDX_D9, 8'h15);
    pstrb <= 4'hF;
    rd(IDX_D9, 8'h3F, "d9 no strobe");
    wr(IDX_D9, 8'hD5);
    rd(IDX_D9, 8'h15, "d9 coarse");
    tmp(9'd101, 8'h00, 1'b0);
    tmp(9'd102, 8'h15, 1'b1);
    wr(IDX_CFG, 8'h21);
    wr(IDX_T9, 8'hB2);
    rd(IDX_T9, 8'hB2, "t9 fine");
    tmp(9'd101, 8'h00, 1'b0);
    tmp(9'd102, 8'h15, 1'b1);
    wr(IDX_CFG, 8'h23);
    wr(IDX_D9, 8'hD5);
    rd(IDX_D9, 8'hD5, "d9 fine");
    tmp(9'd103, 8'h15, 1'b1);
    wr(IDX_CFG, 8'h27);
    tmp(9'd104, 8'hD5, 1'b1);
    wr(IDX_CFG, 8'h25);
    tmp(9'd105, 8'h15, 1'b1);
    wr(IDX_TOFS, 8'h0A);
    rd(IDX_TOFS, 8'h0A, "tofs");
    tmp(9'd121, 8'h00, 1'b0);
    tmp(9'd122, 8'h15, 1'b1);
    wr(IDX_TOFS, 8'h00);
    wr(IDX_T10, 8'hBC);
    wr(IDX_D10, 8'h2A);
    tmp(9'd130, 8'h2A, 1'b1);
    apb(1'b0, {2'b00, IDX_STAT, 2'b00}, 32'h0);
    chk("status", 32'h0000_072A, r);
    wr(IDX_CFG, 8'h04);
    wr(IDX_T10, 8'h00);
    rd(IDX_T10, 8'h3C, "t10 locked");
    rd(IDX_D9, 8'h15, "d9 hidden ext");
    rd(IDX_CFG, 8'h04, "cfg");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pwm_duty in reset", {24'h0, PWM_RST}, {24'h0, pwm_duty});
    presetn <= 1'b1;
    @(posedge pclk);
    rd(IDX_T10, THR_RST, "t10 after reset");
    rd(IDX_CFG, CFG_RST, "cfg after reset");
    end_sim();
  end

  // Whole sequence needs well under 2000 cycles
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end

endmodule // testbench

`default_nettype wire

// ===== fl_pkg.sv
/*
  Constants for the fan lookup table entries nine and ten: register
  indices, field positions and power-on values.
  Assumes an APB slave with 32-bit words; byte address = index * 4.
*/
`default_nettype none

package fl_pkg;

  localparam int unsigned ADDR_W = 12;

  // Register indices
  localparam logic [7:0] IDX_CFG  = 8'h4A;
  localparam logic [7:0] IDX_TOFS = 8'h4E;
  localparam logic [7:0] IDX_STAT = 8'h50;
  localparam logic [7:0] IDX_T9   = 8'h60;
  localparam logic [7:0] IDX_D9   = 8'h61;
  localparam logic [7:0] IDX_T10  = 8'h62;
  localparam logic [7:0] IDX_D10  = 8'h63;

  // Configuration fields
  localparam int unsigned CFG_TEMP_HR_BIT = 0;
  localparam int unsigned CFG_DUTY_HR_BIT = 1;
  localparam int unsigned CFG_FREQ_22K_BIT = 2;
  localparam int unsigned CFG_WEN_BIT     = 5;

  // Status fields
  localparam int unsigned STAT_HIT9_BIT  = 8;
  localparam int unsigned STAT_HIT10_BIT = 9;
  localparam int unsigned STAT_ACT_BIT   = 10;

  // Entry fields
  localparam int unsigned TEMP_HALF_BIT = 7;

  // Power-on values
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] TOFS_RST = 8'h00;
  localparam logic [7:0] THR_RST  = 8'h7F;
  localparam logic [7:0] DUTY_RST = 8'h3F;
  localparam logic [7:0] PWM_RST  = 8'h00;

endpackage : fl_pkg

`default_nettype wire
